// ### design/mad_pkg.sv
// Package with the address map, region codes and port register layout of the decoder.
package mad_pkg;

	// Region codes, one per kind of decoded area of the 64 KB space; reserved and unimplemented codes cover several areas.
	typedef enum logic [3:0] {
		MAD_REG_IO      = 4'h0,
		MAD_REG_RAM     = 4'h1,
		MAD_REG_EEPROM  = 4'h2,
		MAD_REG_ROM     = 4'h3,
		MAD_REG_MONROM  = 4'h4,
		MAD_REG_HIGHREG = 4'h5,
		MAD_REG_VECTOR  = 4'h6,
		MAD_REG_RSVD    = 4'h7,
		MAD_REG_UNIMP   = 4'h8
	} mad_region_e;

	// Region bounds.
	localparam logic [15:0] IO_LO      = 16'h0000;
	localparam logic [15:0] IO_HI      = 16'h003f;
	localparam logic [15:0] UNIMP0_HI  = 16'h004f;
	localparam logic [15:0] RAM_LO     = 16'h0050;
	localparam logic [15:0] RAM_HI     = 16'h044f;
	localparam logic [15:0] RSVD0_HI   = 16'h0451;
	localparam logic [15:0] EE_LO      = 16'h0800;
	localparam logic [15:0] EE_HI      = 16'h09ff;
	localparam logic [15:0] RSVD1_HI   = 16'h0a01;
	localparam logic [15:0] ROM_LO     = 16'h8000;
	localparam logic [15:0] ROM_HI     = 16'hfdff;
	localparam logic [15:0] HREG_LO    = 16'hfe00;
	localparam logic [15:0] HREG_HI    = 16'hfe1f;
	localparam logic [15:0] MON_LO     = 16'hfe20;
	localparam logic [15:0] MON_HI     = 16'hfeff;
	localparam logic [15:0] VEC_LO     = 16'hffdc;

	// High-page register addresses, plus the watchdog register at the last address.
	localparam logic [15:0] SYS_BRK_STAT  = 16'hfe00;
	localparam logic [15:0] SYS_RST_STAT  = 16'hfe01;
	localparam logic [15:0] SYS_BRK_FLAG  = 16'hfe03;
	localparam logic [15:0] BRK_ADDR_HI   = 16'hfe0c;
	localparam logic [15:0] BRK_ADDR_LO   = 16'hfe0d;
	localparam logic [15:0] BRK_STAT_CTL  = 16'hfe0e;
	localparam logic [15:0] LOW_VOLT_STAT = 16'hfe0f;
	localparam logic [15:0] EE_NV_CFG     = 16'hfe1c;
	localparam logic [15:0] EE_CTL        = 16'hfe1d;
	localparam logic [15:0] EE_ARR_CFG    = 16'hfe1f;
	localparam logic [15:0] WDOG_CTL      = 16'hffff;

	// Port register offsets within the I/O block.
	localparam logic [5:0] OFS_PA_DATA = 6'h00;
	localparam logic [5:0] OFS_PB_DATA = 6'h01;
	localparam logic [5:0] OFS_PC_DATA = 6'h02;
	localparam logic [5:0] OFS_PD_DATA = 6'h03;
	localparam logic [5:0] OFS_PA_DIR  = 6'h04;
	localparam logic [5:0] OFS_PB_DIR  = 6'h05;
	localparam logic [5:0] OFS_PC_DIR  = 6'h06;
	localparam logic [5:0] OFS_PD_DIR  = 6'h07;
	localparam logic [5:0] OFS_PE_DATA = 6'h08;
	localparam logic [5:0] OFS_PF_DATA = 6'h09;
	localparam logic [5:0] OFS_RSV_0A  = 6'h0a;
	localparam logic [5:0] OFS_RSV_0B  = 6'h0b;
	localparam logic [5:0] OFS_PE_DIR  = 6'h0c;
	localparam logic [5:0] OFS_PF_DIR  = 6'h0d;
	localparam logic [5:0] OFS_RSV_0E  = 6'h0e;
	localparam logic [5:0] OFS_RSV_0F  = 6'h0f;
	localparam logic [5:0] OFS_RSV_1B  = 6'h1b;
	localparam logic [5:0] OFS_RSV_21  = 6'h21;

	// Implemented-bit masks of the port registers.
	localparam logic [7:0] MASK_FULL   = 8'hff;
	localparam logic [7:0] MASK_PC_DAT = 8'h1f;
	localparam logic [7:0] MASK_PC_DIR = 8'h9f;
	localparam logic [7:0] MASK_PD     = 8'h7f;
	localparam logic [7:0] MASK_PF     = 8'h0f;
	localparam int         BCLK_EN_BIT = 7;

	// Value of port registers after reset: all inputs, data cleared.
	localparam logic [7:0] PORT_RESET  = 8'h00;

endpackage

// ### design/mad_port_regs.sv
// Port data and direction register file at the bottom of the I/O block.
module mad_port_regs (
	// Clock and reset.
	input  wire logic       clock,
	input  wire logic       rstn,
	// Access from the decoder.
	input  wire logic       sel,
	input  wire logic       wr,
	input  wire logic [5:0] offset,
	input  wire logic [7:0] wdata,
	// Read data and hit flag.
	output logic      [7:0] rdata,
	output logic            hit,
	// Register contents.
	output logic      [7:0] pa_data,
	output logic      [7:0] pb_data,
	output logic      [7:0] pc_data,
	output logic      [7:0] pd_data,
	output logic      [7:0] pe_data,
	output logic      [7:0] pf_data,
	output logic      [7:0] pa_dir,
	output logic      [7:0] pb_dir,
	output logic      [7:0] pc_dir,
	output logic      [7:0] pd_dir,
	output logic      [7:0] pe_dir,
	output logic      [7:0] pf_dir
);

	// Storage indexed by register offset 0..13; unimplemented bits are masked on write.
	logic [7:0] regs_reg [0:13];

	// Returns the implemented-bit mask for an offset.
	function automatic logic [7:0] bit_mask(input logic [5:0] ofs);
		case (ofs)
			mad_pkg::OFS_PA_DATA, mad_pkg::OFS_PB_DATA, mad_pkg::OFS_PA_DIR,
			mad_pkg::OFS_PB_DIR, mad_pkg::OFS_PE_DATA, mad_pkg::OFS_PE_DIR:
				bit_mask = mad_pkg::MASK_FULL;
			mad_pkg::OFS_PC_DATA: bit_mask = mad_pkg::MASK_PC_DAT;
			mad_pkg::OFS_PC_DIR:  bit_mask = mad_pkg::MASK_PC_DIR;
			mad_pkg::OFS_PD_DATA: bit_mask = mad_pkg::MASK_PD;
			mad_pkg::OFS_PD_DIR:  bit_mask = mad_pkg::MASK_PD;
			mad_pkg::OFS_PF_DATA: bit_mask = mad_pkg::MASK_PF;
			mad_pkg::OFS_PF_DIR:  bit_mask = mad_pkg::MASK_PF;
			default:              bit_mask = 8'h00;
		endcase
	endfunction

	// Masking at write time keeps unimplemented bits zero, so reads need no mask.
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			for (int i = 0; i < 14; i++) begin
				regs_reg[i] <= mad_pkg::PORT_RESET;
			end
		end else if (sel && wr && bit_mask(offset) != 8'h00) begin
			regs_reg[offset[3:0]] <= wdata & bit_mask(offset);
		end
	end

	// Read data and hit are combinational from the offset.
	always_comb begin
		hit   = (bit_mask(offset) != 8'h00);
		rdata = hit ? regs_reg[offset[3:0]] : 8'h00;
	end

	// Register contents toward the pins.
	assign pa_data = regs_reg[0];
	assign pb_data = regs_reg[1];
	assign pc_data = regs_reg[2];
	assign pd_data = regs_reg[3];
	assign pa_dir  = regs_reg[4];
	assign pb_dir  = regs_reg[5];
	assign pc_dir  = regs_reg[6];
	assign pd_dir  = regs_reg[7];
	assign pe_data = regs_reg[8];
	assign pf_data = regs_reg[9];
	assign pe_dir  = regs_reg[12];
	assign pf_dir  = regs_reg[13];

endmodule

// ### design/mad_decoder.sv
// Address decoder and map of the 64 KB CPU space, with the port register block.
module mad_decoder (
	// Clock and reset.
	input  wire logic        clock,
	input  wire logic        rstn,
	// CPU bus.
	input  wire logic [15:0] addr,
	input  wire logic        valid,
	input  wire logic        wr,
	input  wire logic [7:0]  wdata,
	output logic      [7:0]  port_rdata,
	output logic             port_rdata_valid,
	// Region selects.
	output logic      [3:0]  region,
	output logic             sel_io,
	output logic             sel_ram,
	output logic             sel_eeprom,
	output logic             sel_rom,
	output logic             sel_monrom,
	output logic             sel_vector,
	output logic             sel_reserved,
	output logic             sel_unimpl,
	// High-page register selects, plus the watchdog select at the last address.
	output logic             sel_sys_brk_stat,
	output logic             sel_sys_rst_stat,
	output logic             sel_sys_brk_flag,
	output logic             sel_brk_addr_hi,
	output logic             sel_brk_addr_lo,
	output logic             sel_brk_stat_ctl,
	output logic             sel_low_volt_stat,
	output logic             sel_ee_nv_cfg,
	output logic             sel_ee_ctl,
	output logic             sel_ee_arr_cfg,
	output logic             sel_wdog_ctl,
	// Illegal-address reset.
	input  wire logic        illegal_rst_en,
	output logic             illegal_rst_req,
	// Port registers.
	output logic      [7:0]  pa_data,
	output logic      [7:0]  pb_data,
	output logic      [7:0]  pc_data,
	output logic      [7:0]  pd_data,
	output logic      [7:0]  pe_data,
	output logic      [7:0]  pf_data,
	output logic      [7:0]  pa_dir,
	output logic      [7:0]  pb_dir,
	output logic      [7:0]  pc_dir,
	output logic      [7:0]  pd_dir,
	output logic      [7:0]  pe_dir,
	output logic      [7:0]  pf_dir,
	output logic             bus_clock_output_enable
);

	// Region of the current address.
	mad_pkg::mad_region_e region_now;
	logic                 illegal_rst_reg;
	logic [7:0]           port_rdata_reg;
	logic                 port_rdata_valid_reg;
	logic [7:0]           pr_rdata;
	logic                 pr_hit;
	logic                 io_sel;

	// True when an address is a reserved location inside the I/O block.
	function automatic logic io_reserved(input logic [5:0] ofs);
		io_reserved = (ofs == mad_pkg::OFS_RSV_0A) || (ofs == mad_pkg::OFS_RSV_0B) ||
			(ofs == mad_pkg::OFS_RSV_0E) || (ofs == mad_pkg::OFS_RSV_0F) ||
			(ofs == mad_pkg::OFS_RSV_1B) || (ofs == mad_pkg::OFS_RSV_21);
	endfunction

	// True when a high-page address holds an implemented system register.
	function automatic logic high_impl(input logic [15:0] a);
		high_impl = (a == mad_pkg::SYS_BRK_STAT) || (a == mad_pkg::SYS_RST_STAT) ||
			(a == mad_pkg::SYS_BRK_FLAG) ||
			(a >= mad_pkg::BRK_ADDR_HI && a <= mad_pkg::LOW_VOLT_STAT) ||
			(a == mad_pkg::EE_NV_CFG) || (a == mad_pkg::EE_CTL) ||
			(a == mad_pkg::EE_ARR_CFG);
	endfunction

	// Priority chain gives exactly one region for every address.
	always_comb begin
		if (addr <= mad_pkg::IO_HI) begin
			region_now = io_reserved(addr[5:0]) ? mad_pkg::MAD_REG_RSVD
				: mad_pkg::MAD_REG_IO;
		end else if (addr <= mad_pkg::UNIMP0_HI) begin
			region_now = mad_pkg::MAD_REG_UNIMP;
		end else if (addr <= mad_pkg::RAM_HI) begin
			region_now = mad_pkg::MAD_REG_RAM;
		end else if (addr <= mad_pkg::RSVD0_HI) begin
			region_now = mad_pkg::MAD_REG_RSVD;
		end else if (addr < mad_pkg::EE_LO) begin
			region_now = mad_pkg::MAD_REG_UNIMP;
		end else if (addr <= mad_pkg::EE_HI) begin
			region_now = mad_pkg::MAD_REG_EEPROM;
		end else if (addr <= mad_pkg::RSVD1_HI) begin
			region_now = mad_pkg::MAD_REG_RSVD;
		end else if (addr < mad_pkg::ROM_LO) begin
			region_now = mad_pkg::MAD_REG_UNIMP;
		end else if (addr <= mad_pkg::ROM_HI) begin
			region_now = mad_pkg::MAD_REG_ROM;
		end else if (addr <= mad_pkg::HREG_HI) begin
			region_now = high_impl(addr) ? mad_pkg::MAD_REG_HIGHREG
				: mad_pkg::MAD_REG_RSVD;
		end else if (addr <= mad_pkg::MON_HI) begin
			region_now = mad_pkg::MAD_REG_MONROM;
		end else if (addr < mad_pkg::VEC_LO) begin
			region_now = mad_pkg::MAD_REG_UNIMP;
		end else begin
			region_now = mad_pkg::MAD_REG_VECTOR;
		end
	end

	// Region selects, each qualified by a valid bus cycle.
	assign region       = region_now;
	assign sel_io       = valid && region_now == mad_pkg::MAD_REG_IO;
	assign sel_ram      = valid && region_now == mad_pkg::MAD_REG_RAM;
	assign sel_eeprom   = valid && region_now == mad_pkg::MAD_REG_EEPROM;
	assign sel_rom      = valid && region_now == mad_pkg::MAD_REG_ROM;
	assign sel_monrom   = valid && region_now == mad_pkg::MAD_REG_MONROM;
	assign sel_vector   = valid && region_now == mad_pkg::MAD_REG_VECTOR;
	// Reserved hits are only reported; the master is trusted to avoid them.
	assign sel_reserved = valid && region_now == mad_pkg::MAD_REG_RSVD;
	assign sel_unimpl   = valid && region_now == mad_pkg::MAD_REG_UNIMP;

	// High-page register selects, plus the watchdog select at the last address.
	assign sel_sys_brk_stat  = valid && addr == mad_pkg::SYS_BRK_STAT;
	assign sel_sys_rst_stat  = valid && addr == mad_pkg::SYS_RST_STAT;
	assign sel_sys_brk_flag  = valid && addr == mad_pkg::SYS_BRK_FLAG;
	assign sel_brk_addr_hi   = valid && addr == mad_pkg::BRK_ADDR_HI;
	assign sel_brk_addr_lo   = valid && addr == mad_pkg::BRK_ADDR_LO;
	assign sel_brk_stat_ctl  = valid && addr == mad_pkg::BRK_STAT_CTL;
	assign sel_low_volt_stat = valid && addr == mad_pkg::LOW_VOLT_STAT;
	assign sel_ee_nv_cfg     = valid && addr == mad_pkg::EE_NV_CFG;
	assign sel_ee_ctl        = valid && addr == mad_pkg::EE_CTL;
	assign sel_ee_arr_cfg    = valid && addr == mad_pkg::EE_ARR_CFG;
	// The watchdog register overlays the last vector byte, so both selects rise together.
	assign sel_wdog_ctl      = valid && addr == mad_pkg::WDOG_CTL;

	// Reset request high for every cycle an unimplemented access is held, registered for clean timing.
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			illegal_rst_reg <= 1'b0;
		end else begin
			illegal_rst_reg <= sel_unimpl && illegal_rst_en;
		end
	end
	assign illegal_rst_req = illegal_rst_reg;

	// Port registers live in the I/O block only.
	assign io_sel = sel_io;

	mad_port_regs u_port_regs (
		.clock   (clock),
		.rstn    (rstn),
		.sel     (io_sel),
		.wr      (wr),
		.offset  (addr[5:0]),
		.wdata   (wdata),
		.rdata   (pr_rdata),
		.hit     (pr_hit),
		.pa_data (pa_data),
		.pb_data (pb_data),
		.pc_data (pc_data),
		.pd_data (pd_data),
		.pe_data (pe_data),
		.pf_data (pf_data),
		.pa_dir  (pa_dir),
		.pb_dir  (pb_dir),
		.pc_dir  (pc_dir),
		.pd_dir  (pd_dir),
		.pe_dir  (pe_dir),
		.pf_dir  (pf_dir)
	);

	// Read data is registered: it appears the cycle after a port read.
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			port_rdata_reg       <= 8'h00;
			port_rdata_valid_reg <= 1'b0;
		end else begin
			port_rdata_reg       <= pr_rdata;
			port_rdata_valid_reg <= io_sel && !wr && pr_hit;
		end
	end
	assign port_rdata       = port_rdata_reg;
	assign port_rdata_valid = port_rdata_valid_reg;

	// Bus clock output enable is the top bit of port C direction.
	assign bus_clock_output_enable = pc_dir[mad_pkg::BCLK_EN_BIT];

	// Assertions.
	a_illegal_pulse: assert property (@(posedge clock) disable iff (!rstn)
		(valid && region_now == mad_pkg::MAD_REG_UNIMP && illegal_rst_en)
		|=> illegal_rst_req) else $error("illegal access did not request reset");
	a_illegal_gated: assert property (@(posedge clock) disable iff (!rstn)
		!(sel_unimpl && illegal_rst_en) |=> !illegal_rst_req)
		else $error("reset request without enabled illegal access");
	a_one_region: assert property (@(posedge clock) disable iff (!rstn)
		valid |-> $onehot({sel_io, sel_ram, sel_eeprom, sel_rom, sel_monrom,
		sel_vector, sel_reserved, sel_unimpl, region_now == mad_pkg::MAD_REG_HIGHREG}))
		else $error("address did not select exactly one region");
	a_ram_range: assert property (@(posedge clock) disable iff (!rstn)
		sel_ram |-> (addr >= mad_pkg::RAM_LO && addr <= mad_pkg::RAM_HI))
		else $error("RAM selected outside its range");
	a_rom_range: assert property (@(posedge clock) disable iff (!rstn)
		(valid && addr >= mad_pkg::ROM_LO && addr <= mad_pkg::ROM_HI) |-> sel_rom)
		else $error("ROM not selected in its range");
	a_monrom_range: assert property (@(posedge clock) disable iff (!rstn)
		(valid && addr >= mad_pkg::MON_LO && addr <= mad_pkg::MON_HI) |-> sel_monrom)
		else $error("monitor ROM not selected");
	a_vec_wdog: assert property (@(posedge clock) disable iff (!rstn)
		sel_wdog_ctl |-> sel_vector) else $error("watchdog select outside vectors");
	a_eeprom_range: assert property (@(posedge clock) disable iff (!rstn)
		(valid && addr >= mad_pkg::EE_LO && addr <= mad_pkg::EE_HI) |-> sel_eeprom)
		else $error("EEPROM not selected");
	a_pc_data_bits: assert property (@(posedge clock) disable iff (!rstn)
		(pc_data & ~mad_pkg::MASK_PC_DAT) == 8'h00)
		else $error("port C data upper bits set");
	a_pd_bits: assert property (@(posedge clock) disable iff (!rstn)
		!pd_data[7] && !pd_dir[7]) else $error("port D bit 7 set");
	a_pf_bits: assert property (@(posedge clock) disable iff (!rstn)
		(pf_data[7:4] == 4'h0) && (pf_dir[7:4] == 4'h0))
		else $error("port F upper bits set");
	a_pc_dir_write: assert property (@(posedge clock) disable iff (!rstn)
		(sel_io && wr && addr[5:0] == mad_pkg::OFS_PC_DIR)
		|=> pc_dir == ($past(wdata) & mad_pkg::MASK_PC_DIR))
		else $error("port C direction write wrong");
	a_pa_write: assert property (@(posedge clock) disable iff (!rstn)
		(sel_io && wr && addr[5:0] == mad_pkg::OFS_PA_DATA) |=> pa_data == $past(wdata))
		else $error("port A data write lost");

endmodule

// ### testbench/mad_cpu_model.sv
// Bus master model standing in for the processor core in front of the decoder.
module mad_cpu_model (
	// Clock.
	input  wire logic        clock,
	// Bus driven towards the decoder.
	output logic      [15:0] addr,
	output logic             valid,
	output logic             wr,
	output logic      [7:0]  wdata
);
	timeunit 1ns;
	timeprecision 1ns;

	// Idle bus at time zero, with no cycle in progress.
	initial begin
		addr = 16'h0000;
		valid = 1'b0;
		wr = 1'b0;
		wdata = 8'h00;
	end

	// Presents one cycle just after an edge and lets it settle for sampling.
	// Reserved places are reached only when a scenario asks for them on purpose.
	task automatic start(input logic [15:0] a, input logic w, input logic [7:0] d);
		@(posedge clock);
		addr <= a;
		valid <= 1'b1;
		wr <= w;
		wdata <= d;
		#5;
	endtask

	// Ends the cycle at the taking edge; valid and wr drop low, address and write data show inverted values.
	// A stale address left on the bus could hide a decoder that ignores valid.
	task automatic done();
		@(posedge clock);
		valid <= 1'b0;
		wr <= 1'b0;
		addr <= ~addr;
		wdata <= ~wdata;
	endtask
endmodule

// ### testbench/mad_decoder_test.sv
// Self-checking bench of the address decoder driven through the bus master model.
module mad_decoder_test;
	timeunit 1ns;
	timeprecision 1ns;

	logic        clock, rstn, illegal_rst_en, valid, wr;
	logic [15:0] addr;
	logic [7:0]  wdata, port_rdata;
	logic [3:0]  region;
	logic        port_rdata_valid, illegal_rst_req, bus_clock_output_enable;
	logic        sel_io, sel_ram, sel_eeprom, sel_rom, sel_monrom, sel_vector, sel_reserved;
	logic        sel_unimpl, sel_sys_brk_stat, sel_sys_rst_stat, sel_sys_brk_flag;
	logic        sel_brk_addr_hi, sel_brk_addr_lo, sel_brk_stat_ctl, sel_low_volt_stat;
	logic        sel_ee_nv_cfg, sel_ee_ctl, sel_ee_arr_cfg, sel_wdog_ctl;
	logic [7:0]  pa_data, pb_data, pc_data, pd_data, pe_data, pf_data;
	logic [7:0]  pa_dir, pb_dir, pc_dir, pd_dir, pe_dir, pf_dir;
	int          mismatches = 0;
	int          checks = 0;

	// Grouped views of the outputs; port contents follow offset order.
	wire [7:0]  rsel = {sel_io, sel_ram, sel_eeprom, sel_rom, sel_monrom, sel_vector,
		sel_reserved, sel_unimpl};
	wire [10:0] hsel = {sel_sys_brk_stat, sel_sys_rst_stat, sel_sys_brk_flag, sel_brk_addr_hi,
		sel_brk_addr_lo, sel_brk_stat_ctl, sel_low_volt_stat, sel_ee_nv_cfg, sel_ee_ctl,
		sel_ee_arr_cfg, sel_wdog_ctl};
	wire [95:0] regs = {pa_data, pb_data, pc_data, pd_data, pa_dir, pb_dir, pc_dir, pd_dir,
		pe_data, pf_data, pe_dir, pf_dir};

	// Boundary addresses with their region code in the low nibble.
	localparam logic [19:0] MAP [27] = '{20'h00000, 20'h003f0, 20'h00408, 20'h004f8, 20'h00501,
		20'h044f1, 20'h04507, 20'h04517, 20'h04528, 20'h07ff8, 20'h08002, 20'h09ff2, 20'h0a007,
		20'h0a017, 20'h0a028, 20'h7fff8, 20'h80003, 20'hfdff3, 20'hfe005, 20'hfe027, 20'hfe1f5,
		20'hfe204, 20'hfeff4, 20'hff008, 20'hffdb8, 20'hffdc6, 20'hffff6};
	localparam logic [15:0] IORSV [6] = '{16'h000a, 16'h000b, 16'h000e, 16'h000f, 16'h001b,
		16'h0021};
	localparam logic [15:0] HP [11] = '{16'hfe00, 16'hfe01, 16'hfe03, 16'hfe0c, 16'hfe0d,
		16'hfe0e, 16'hfe0f, 16'hfe1c, 16'hfe1d, 16'hfe1f, 16'hffff};
	// Port offset in the high byte, implemented-bit mask in the low byte.
	localparam logic [15:0] PORTS [12] = '{16'h00ff, 16'h01ff, 16'h021f, 16'h037f, 16'h04ff,
		16'h05ff, 16'h069f, 16'h077f, 16'h08ff, 16'h090f, 16'h0cff, 16'h0d0f};

	mad_cpu_model mad_cpu_model_i (.clock(clock), .addr(addr), .valid(valid), .wr(wr),
		.wdata(wdata));

	mad_decoder mad_decoder_i (.clock(clock), .rstn(rstn), .addr(addr), .valid(valid),
		.wr(wr), .wdata(wdata), .port_rdata(port_rdata), .port_rdata_valid(port_rdata_valid),
		.region(region), .sel_io(sel_io), .sel_ram(sel_ram), .sel_eeprom(sel_eeprom),
		.sel_rom(sel_rom), .sel_monrom(sel_monrom), .sel_vector(sel_vector),
		.sel_reserved(sel_reserved), .sel_unimpl(sel_unimpl),
		.sel_sys_brk_stat(sel_sys_brk_stat), .sel_sys_rst_stat(sel_sys_rst_stat),
		.sel_sys_brk_flag(sel_sys_brk_flag), .sel_brk_addr_hi(sel_brk_addr_hi),
		.sel_brk_addr_lo(sel_brk_addr_lo), .sel_brk_stat_ctl(sel_brk_stat_ctl),
		.sel_low_volt_stat(sel_low_volt_stat), .sel_ee_nv_cfg(sel_ee_nv_cfg),
		.sel_ee_ctl(sel_ee_ctl), .sel_ee_arr_cfg(sel_ee_arr_cfg), .sel_wdog_ctl(sel_wdog_ctl),
		.illegal_rst_en(illegal_rst_en), .illegal_rst_req(illegal_rst_req),
		.pa_data(pa_data), .pb_data(pb_data), .pc_data(pc_data), .pd_data(pd_data),
		.pe_data(pe_data), .pf_data(pf_data), .pa_dir(pa_dir), .pb_dir(pb_dir),
		.pc_dir(pc_dir), .pd_dir(pd_dir), .pe_dir(pe_dir), .pf_dir(pf_dir),
		.bus_clock_output_enable(bus_clock_output_enable));

	// Free-running bus clock, 50 ns period.
	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end

	// Compares with case inequality so an unknown never passes.
	task automatic chk(input logic [95:0] got, input logic [95:0] exp);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Expected region select bits for a region code; the high page has no select line.
	function automatic logic [7:0] exp_sel(input logic [3:0] r);
		case (r)
			4'h0: return 8'h80;
			4'h1: return 8'h40;
			4'h2: return 8'h20;
			4'h3: return 8'h10;
			4'h4: return 8'h08;
			4'h6: return 8'h04;
			4'h7: return 8'h02;
			4'h8: return 8'h01;
			default: return 8'h00;
		endcase
	endfunction

	// Walks region boundaries with resets enabled; only unimplemented ones may request.
	task automatic test_map();
		@(posedge clock) illegal_rst_en <= 1'b1;
		for (int i = 0; i < 27; i++) begin
			mad_cpu_model_i.start(MAP[i][19:4], 1'b0, 8'h00);
			chk(region, MAP[i][3:0]);
			chk(rsel, exp_sel(MAP[i][3:0]));
			mad_cpu_model_i.done();
			#5 chk(illegal_rst_req, MAP[i][3:0] == 4'h8);
		end
		for (int i = 0; i < 6; i++) begin
			mad_cpu_model_i.start(IORSV[i], 1'b0, 8'h00);
			chk(sel_unimpl, 1'b0);
			mad_cpu_model_i.done();
			#5 chk(illegal_rst_req, 1'b0);
		end
	endtask

	// Request is gated by the enable, and a held cycle keeps it high for each edge it is held.
	task automatic test_pulse();
		@(posedge clock) illegal_rst_en <= 1'b0;
		mad_cpu_model_i.start(16'h0040, 1'b0, 8'h00);
		mad_cpu_model_i.done();
		#5 chk(illegal_rst_req, 1'b0);
		@(posedge clock) illegal_rst_en <= 1'b1;
		mad_cpu_model_i.start(16'hff00, 1'b0, 8'h00);
		@(posedge clock) #5 chk(illegal_rst_req, 1'b1);
		mad_cpu_model_i.done();
		#5 chk(illegal_rst_req, 1'b1);
		@(posedge clock) #5 chk(illegal_rst_req, 1'b0);
	endtask

	// Every high-page location and the last address against the register selects.
	task automatic test_high();
		logic [15:0] a;
		logic [10:0] e;
		for (int k = 0; k < 33; k++) begin
			a = (k == 32) ? 16'hffff : 16'hfe00 + 16'(k);
			e = 11'h000;
			for (int i = 0; i < 11; i++)
				if (HP[i] == a) e[10-i] = 1'b1;
			mad_cpu_model_i.start(a, 1'b0, 8'h00);
			chk(hsel, e);
			if (k == 32) chk(sel_vector, 1'b1);
			mad_cpu_model_i.done();
		end
	endtask

	// Writes all ones to every port register and reads back only implemented bits.
	task automatic test_ports();
		for (int i = 0; i < 12; i++) begin
			mad_cpu_model_i.start({8'h00, PORTS[i][15:8]}, 1'b1, 8'hff);
			mad_cpu_model_i.done();
		end
		for (int i = 0; i < 12; i++) begin
			mad_cpu_model_i.start({8'h00, PORTS[i][15:8]}, 1'b0, 8'h00);
			mad_cpu_model_i.done();
			#5 chk(port_rdata_valid, 1'b1);
			chk(port_rdata, PORTS[i][7:0]);
			chk(regs[95-8*i -: 8], PORTS[i][7:0]);
		end
		chk(bus_clock_output_enable, 1'b1);
		mad_cpu_model_i.start(16'h0006, 1'b1, 8'h00);
		mad_cpu_model_i.done();
		#5 chk(bus_clock_output_enable, 1'b0);
		mad_cpu_model_i.start(16'h000a, 1'b0, 8'h00);
		mad_cpu_model_i.done();
		#5 chk(port_rdata_valid, 1'b0);
	endtask

	// Prints the counts and the verdict, then ends the run.
	task automatic stop_test();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// Main sequence: ten cycles of reset, then each scenario in turn.
	initial begin
		rstn = 1'b0;
		illegal_rst_en = 1'b0;
		repeat (10) @(posedge clock);
		rstn <= 1'b1;
		@(posedge clock) #5 chk(regs, 96'h0);
		chk(illegal_rst_req, 1'b0);
		test_map();
		test_pulse();
		test_high();
		test_ports();
		stop_test();
	end

	// Watchdog: the scenarios need well under a thousand cycles.
	initial begin
		#(5000 * 50);
		mismatches++;
		stop_test();
	end
endmodule
